// File: shared/ihw_defines.svh
// Register offsets, field positions and reset values of the indirect host write port
`ifndef IHW_DEFINES_SVH
`define IHW_DEFINES_SVH
`define IHW_PANEL_W   8'h16
`define IHW_PANEL_HLO 8'h1A
`define IHW_PANEL_HHI 8'h1C
`define IHW_DISP_SRC  8'h2A
`define IHW_WCTL      8'h52
`define IHW_KEY_LO    8'h54
`define IHW_KEY_HI    8'h56
`define IHW_XS        8'h5A
`define IHW_XE        8'h5C
`define IHW_YS_LO     8'h5E
`define IHW_YS_HI     8'h60
`define IHW_YE_LO     8'h62
`define IHW_YE_HI     8'h64
`define IHW_PORT_LO   8'h66
`define IHW_PORT_HI   8'h67
`define IHW_BUF_SIZE  8'h90
`define IHW_REG_STEP  8'h02
`define IHW_RST8      8'h00
`define IHW_STRAP_RST 1'b1
`define IHW_BSEL_HI   7
`define IHW_BSEL_LO   4
`define IHW_TRANS_BIT 3
`define IHW_MIR_BIT   1
`define IHW_ROT_BIT   0
`define IHW_APB_CMD   12'h000
`define IHW_APB_WDAT  12'h004
`define IHW_APB_RDAT  12'h008
`define IHW_APB_STAT  12'h00C
`define IHW_CMD_ADDR  0
`define IHW_CMD_WR    1
`endif

// File: shared/ihw_pkg.sv
// Types shared by both ends of the indirect host write port
`default_nettype none
package ihw_pkg;
  typedef enum logic {IHW_WK_IDLE, IHW_WK_RUN} ihw_walk_t;
  typedef enum logic [1:0] {IHW_H_IDLE, IHW_H_ISSUE, IHW_H_WAIT} ihw_hst_t;
endpackage
`default_nettype wire

// File: shared/ihw_if.sv
// Parallel host port between host controller and display write port
`timescale 1ns/10ps
`default_nettype none
interface ihw_if;
  logic        req;
  logic        is_addr;
  logic        wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  logic        bus_width_strap;
  modport dev  (input req, is_addr, wr, wdata, bus_width_strap, output rdata, rvalid);
  modport host (output req, is_addr, wr, wdata, bus_width_strap, input rdata, rvalid);
endinterface
`default_nettype wire

// File: core/ihw_map.sv
// Window pixel to buffer offset with mirror and rotation
`timescale 1ns/10ps
`default_nettype none
module ihw_map (
  input  wire logic [10:0] x,
  input  wire logic [9:0]  y,
  input  wire logic [7:0]  pw,
  input  wire logic [9:0]  ph,
  input  wire logic        mir,
  input  wire logic        rot,
  output logic      [20:0] off
);
  logic [10:0] wpx;
  logic [10:0] xf;
  logic [9:0]  yf;
  always_comb begin
    wpx = {pw, 3'b000};
    xf  = (mir ^ rot) ? (wpx - 11'd1 - x) : x;
    yf  = rot ? (ph - 10'd1 - y) : y;
    off = ({11'd0, yf} * {10'd0, wpx}) + {10'd0, xf};
  end
endmodule
`default_nettype wire

// File: core/ihw_dev.sv
// Device end: indirect register port and write window engine
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "ihw_defines.svh"
// Summary of operation
// - Registers are 8-bit; pixel port 16-bit
// - 16-bit bus: registers use low lanes
// - Pixel port: both bytes wide, low only narrow
// - Host writes address, then data cycles
// - Data access advances register or memory address
// - Register address is eight bits
// - Display memory is never read back
// - Host writes six coordinates from X start
// - After coordinates, address lands on pixel port
// - Direct port bursts reuse old coordinates
// - X in eight pixel units, Y lines
// - Coordinates relative to display top left
// - Write control upper nibble picks buffer
// - Display source upper nibble picks buffer
// - At most sixteen buffers, sized by register
// - Window writes overwrite buffer contents
// - Transparency skips pixels equal key colour
// - Rotation stores data turned 180 degrees
// - Mirror stores each line reversed
// - Both: mirror then rotate
// - Host sets panel size before pixels
module ihw_dev
  import ihw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  ihw_if.dev               hp,
  output logic             mem_we,
  output logic [3:0]       mem_buf,
  output logic [23:0]      mem_addr,
  output logic [15:0]      mem_data,
  output logic [3:0]       disp_src,
  output logic             walk_busy
);
  logic [2:0]  sync_r;
  logic        bus8_r;
  logic [7:0]  addr_r;
  logic [7:0]  pw_r, phl_r, phh_r, src_r, wctl_r, kl_r, kh_r;
  logic [7:0]  xs_r, xe_r, ysl_r, ysh_r, yel_r, yeh_r, bsz_r;
  logic [7:0]  rd_mux;
  logic [15:0] rdata_r;
  logic        rvalid_r;
  logic        half_r;
  logic [7:0]  lat_r;
  logic [10:0] cx_r;
  logic [9:0]  cy_r;
  ihw_walk_t   st_r;
  logic        mem_we_r;
  logic [3:0]  mem_buf_r;
  logic [23:0] mem_addr_r;
  logic [15:0] mem_data_r;
  logic        data_acc, addr_wr, port_hit, wr_reg, wr_port, pix_go, ld, skip;
  logic [15:0] pix;
  logic [20:0] off;
  logic [11:0] base;
  logic [10:0] xstart, xend;
  logic [9:0]  ystart, yend, ph;

  // Bus width strap filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= {3{`IHW_STRAP_RST}};
      bus8_r <= `IHW_STRAP_RST;
    end else begin
      sync_r <= {sync_r[1:0], hp.bus_width_strap};
      if (sync_r[1] == sync_r[2]) begin
        bus8_r <= sync_r[2];
      end
    end
  end

  always_comb begin
    data_acc = hp.req & ~hp.is_addr;
    addr_wr  = hp.req & hp.is_addr & hp.wr;
    port_hit = (addr_r == `IHW_PORT_LO) | (addr_r == `IHW_PORT_HI);
    wr_reg   = data_acc & hp.wr & ~port_hit;
    wr_port  = data_acc & hp.wr & port_hit;
    pix_go   = wr_port & (~bus8_r | half_r);
    pix      = bus8_r ? {hp.wdata[7:0], lat_r} : hp.wdata;
    ld       = (addr_wr & (hp.wdata[7:0] == `IHW_PORT_LO))
             | (wr_reg & (addr_r == `IHW_YE_HI));
    xstart   = {xs_r, 3'b000};
    xend     = {xe_r, 3'b111};
    ystart   = {ysh_r[1:0], ysl_r};
    yend     = {yeh_r[1:0], yel_r};
    ph       = {phh_r[1:0], phl_r};
    base     = {8'h00, wctl_r[`IHW_BSEL_HI:`IHW_BSEL_LO]} * {4'h0, bsz_r};
    skip     = wctl_r[`IHW_TRANS_BIT] & (pix == {kh_r, kl_r});
  end

  // Register address pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= `IHW_RST8;
    end else if (addr_wr) begin
      addr_r <= hp.wdata[7:0];
    end else if (data_acc & ~port_hit) begin
      addr_r <= addr_r + `IHW_REG_STEP;
    end
  end

  // Register file, low lanes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pw_r, phl_r, phh_r, src_r, wctl_r, kl_r, kh_r} <= '0;
      {xs_r, xe_r, ysl_r, ysh_r, yel_r, yeh_r, bsz_r} <= '0;
    end else if (wr_reg) begin
      case (addr_r)
        `IHW_PANEL_W:   pw_r   <= hp.wdata[7:0];
        `IHW_PANEL_HLO: phl_r  <= hp.wdata[7:0];
        `IHW_PANEL_HHI: phh_r  <= hp.wdata[7:0];
        `IHW_DISP_SRC:  src_r  <= hp.wdata[7:0];
        `IHW_WCTL:      wctl_r <= hp.wdata[7:0];
        `IHW_KEY_LO:    kl_r   <= hp.wdata[7:0];
        `IHW_KEY_HI:    kh_r   <= hp.wdata[7:0];
        `IHW_XS:        xs_r   <= hp.wdata[7:0];
        `IHW_XE:        xe_r   <= hp.wdata[7:0];
        `IHW_YS_LO:     ysl_r  <= hp.wdata[7:0];
        `IHW_YS_HI:     ysh_r  <= hp.wdata[7:0];
        `IHW_YE_LO:     yel_r  <= hp.wdata[7:0];
        `IHW_YE_HI:     yeh_r  <= hp.wdata[7:0];
        `IHW_BUF_SIZE:  bsz_r  <= hp.wdata[7:0];
        default:        ;
      endcase
    end
  end

  // Read back, pixel port reads as zero
  always_comb begin
    case (addr_r)
      `IHW_PANEL_W:   rd_mux = pw_r;
      `IHW_PANEL_HLO: rd_mux = phl_r;
      `IHW_PANEL_HHI: rd_mux = phh_r;
      `IHW_DISP_SRC:  rd_mux = src_r;
      `IHW_WCTL:      rd_mux = wctl_r;
      `IHW_KEY_LO:    rd_mux = kl_r;
      `IHW_KEY_HI:    rd_mux = kh_r;
      `IHW_XS:        rd_mux = xs_r;
      `IHW_XE:        rd_mux = xe_r;
      `IHW_YS_LO:     rd_mux = ysl_r;
      `IHW_YS_HI:     rd_mux = ysh_r;
      `IHW_YE_LO:     rd_mux = yel_r;
      `IHW_YE_HI:     rd_mux = yeh_r;
      `IHW_BUF_SIZE:  rd_mux = bsz_r;
      default:        rd_mux = `IHW_RST8;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= data_acc & ~hp.wr;
      if (data_acc & ~hp.wr) begin
        rdata_r <= {8'h00, rd_mux};
      end
    end
  end

  // Byte pairing on the narrow bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_r <= 1'b0;
      lat_r  <= `IHW_RST8;
    end else if (addr_wr) begin
      half_r <= 1'b0;
    end else if (wr_port & bus8_r) begin
      half_r <= ~half_r;
      lat_r  <= hp.wdata[7:0];
    end
  end

  // Window walk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= IHW_WK_IDLE;
      cx_r <= '0;
      cy_r <= '0;
    end else if (ld) begin
      st_r <= IHW_WK_RUN;
      cx_r <= xstart;
      cy_r <= ystart;
    end else if (pix_go) begin
      case (st_r)
        IHW_WK_RUN: begin
          if (cx_r == xend) begin
            cx_r <= xstart;
            if (cy_r == yend) begin
              st_r <= IHW_WK_IDLE;
            end else begin
              cy_r <= cy_r + 10'd1;
            end
          end else begin
            cx_r <= cx_r + 11'd1;
          end
        end
        default: st_r <= IHW_WK_IDLE;
      endcase
    end
  end

  ihw_map u_map (
    .x   (cx_r),
    .y   (cy_r),
    .pw  (pw_r),
    .ph  (ph),
    .mir (wctl_r[`IHW_MIR_BIT]),
    .rot (wctl_r[`IHW_ROT_BIT]),
    .off (off)
  );

  // Buffer write port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_we_r   <= 1'b0;
      mem_buf_r  <= '0;
      mem_addr_r <= '0;
      mem_data_r <= '0;
    end else begin
      mem_we_r <= pix_go & (st_r == IHW_WK_RUN) & ~skip;
      if (pix_go) begin
        mem_buf_r  <= wctl_r[`IHW_BSEL_HI:`IHW_BSEL_LO];
        mem_addr_r <= {base, 12'h000} + {3'b000, off};
        mem_data_r <= pix;
      end
    end
  end

  assign hp.rdata  = rdata_r;
  assign hp.rvalid = rvalid_r;
  assign mem_we    = mem_we_r;
  assign mem_buf   = mem_buf_r;
  assign mem_addr  = mem_addr_r;
  assign mem_data  = mem_data_r;
  assign disp_src  = src_r[`IHW_BSEL_HI:`IHW_BSEL_LO];
  assign walk_busy = (st_r == IHW_WK_RUN);
endmodule
`default_nettype wire

// File: core/ihw_host.sv
// Host end: APB command registers driving the parallel host port
`timescale 1ns/10ps
`default_nettype none
`include "ihw_defines.svh"
module ihw_host
  import ihw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus8_sel,
  ihw_if.host              hp
);
  ihw_hst_t    st_r;
  logic [1:0]  cmd_r;
  logic [15:0] wdat_r;
  logic [15:0] rdat_r;
  logic        strap_r;
  logic        req_r;
  logic        acc, wr_acc, hit;

  always_comb begin
    acc    = psel & penable;
    wr_acc = acc & pwrite;
    hit    = (paddr == `IHW_APB_CMD) | (paddr == `IHW_APB_WDAT)
           | (paddr == `IHW_APB_RDAT) | (paddr == `IHW_APB_STAT);
    pready  = 1'b1;
    pslverr = acc & ~hit;
    case (paddr)
      `IHW_APB_CMD:  prdata = {30'd0, cmd_r};
      `IHW_APB_WDAT: prdata = {16'd0, wdat_r};
      `IHW_APB_RDAT: prdata = {16'd0, rdat_r};
      `IHW_APB_STAT: prdata = {31'd0, st_r != IHW_H_IDLE};
      default:       prdata = '0;
    endcase
  end

  // Cycle sequencer, one port cycle per command write, reads wait for rvalid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= IHW_H_IDLE;
      req_r <= 1'b0;
      cmd_r <= '0;
    end else begin
      req_r <= 1'b0;
      case (st_r)
        IHW_H_IDLE: begin
          if (wr_acc & (paddr == `IHW_APB_CMD)) begin
            cmd_r <= pwdata[1:0];
            req_r <= 1'b1;
            st_r  <= IHW_H_ISSUE;
          end
        end
        IHW_H_ISSUE: st_r <= cmd_r[`IHW_CMD_WR] ? IHW_H_IDLE : IHW_H_WAIT;
        IHW_H_WAIT:  st_r <= hp.rvalid ? IHW_H_IDLE : IHW_H_WAIT;
        default:     st_r <= IHW_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdat_r <= '0;
    end else if (wr_acc & (paddr == `IHW_APB_WDAT) & (st_r == IHW_H_IDLE)) begin
      wdat_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdat_r <= '0;
    end else if (hp.rvalid & (st_r == IHW_H_WAIT)) begin
      rdat_r <= hp.rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_r <= `IHW_STRAP_RST;
    end else begin
      strap_r <= bus8_sel;
    end
  end

  assign hp.req             = req_r;
  assign hp.is_addr         = cmd_r[`IHW_CMD_ADDR];
  assign hp.wr              = cmd_r[`IHW_CMD_WR];
  assign hp.wdata           = wdat_r;
  assign hp.bus_width_strap = strap_r;
endmodule
`default_nettype wire

// File: bench/ihw_asserts.sv
// Checker of the port link between host and device ends
`timescale 1ns/10ps
`default_nettype none
module ihw_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        req,
  input wire logic        is_addr,
  input wire logic        wr,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        bus_width_strap
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_read_gets_answer: assert property (req && !wr && !is_addr |=> rvalid) else $error("read not answered");
  a_answer_has_cause: assert property (rvalid |-> $past(req & ~wr & ~is_addr)) else $error("stray answer");
  a_rdata_low_lanes: assert property (rvalid |-> rdata[15:8] == 8'h00) else $error("high lanes");
  a_req_one_cycle: assert property (req |=> !req) else $error("request too long");
  a_rvalid_one_cycle: assert property (rvalid |=> !rvalid) else $error("answer too long");
  a_addr_is_write: assert property (req && is_addr |-> wr) else $error("address cycle read");
  a_rdata_holds: assert property (!rvalid |-> $stable(rdata)) else $error("read data moved");
  a_strap_quiet: assert property ($changed(bus_width_strap) |-> !req) else $error("strap moved in cycle");
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench joining host and device ends
`timescale 1ns/10ps
`default_nettype none
`include "ihw_defines.svh"
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bus8_sel;
  logic        mem_we;
  logic [3:0]  mem_buf;
  logic [23:0] mem_addr;
  logic [15:0] mem_data;
  logic [3:0]  disp_src;
  logic        walk_busy;
  logic [31:0] r;
  logic        se;
  int          err_total;
  int          total_checks;
  logic [23:0] qa[$];
  logic [15:0] qd[$];
  ihw_if hp_link();
  ihw_host u_ihw_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus8_sel(bus8_sel), .hp(hp_link.host));
  ihw_dev u_ihw_dev (.pclk(pclk), .presetn(presetn), .hp(hp_link.dev), .mem_we(mem_we), .mem_buf(mem_buf),
    .mem_addr(mem_addr), .mem_data(mem_data), .disp_src(disp_src), .walk_busy(walk_busy));
  ihw_asserts u_ihw_asserts (.pclk(pclk), .presetn(presetn), .req(hp_link.req), .is_addr(hp_link.is_addr),
    .wr(hp_link.wr), .rdata(hp_link.rdata), .rvalid(hp_link.rvalid), .bus_width_strap(hp_link.bus_width_strap));
  always #25 pclk = ~pclk;
  // Stored pixels, seen mid-cycle
  always @(negedge pclk) begin
    if (mem_we === 1'b1) begin
      qa.push_back(mem_addr);
      qd.push_back(mem_data);
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task port(input logic [1:0] c, input logic [15:0] d);
    int n;
    apb(1'b1, `IHW_APB_WDAT, {16'h0000, d});
    apb(1'b1, `IHW_APB_CMD, {30'h0, c});
    n = 0;
    do begin
      apb(1'b0, `IHW_APB_STAT, 32'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 100);
    if (r[0] !== 1'b0) begin
      chk("port_busy", {31'h0, r[0]}, 32'h0);
    end
  endtask
  task aw(input logic [7:0] a);
    port(2'h3, {8'h00, a});
  endtask
  task dw(input logic [15:0] d);
    port(2'h2, d);
  endtask
  task rd(input string nm, input logic [31:0] exp);
    port(2'h0, 16'h0000);
    apb(1'b0, `IHW_APB_RDAT, 32'h0);
    chk(nm, r, exp);
  endtask
  task px(input logic [23:0] a, input logic [15:0] d);
    if (qa.size() == 0) begin
      chk("mem_we", 32'h0, 32'h1);
    end else begin
      chk("mem_addr", {8'h00, qa.pop_front()}, {8'h00, a});
      chk("mem_data", {16'h0000, qd.pop_front()}, {16'h0000, d});
    end
  endtask
  task t_regs;
    aw(`IHW_KEY_LO);
    dw(16'h12A5);
    dw(16'h003C);
    port(2'h3, 16'h0154);
    rd("key_lo", 32'hA5);
    rd("key_hi", 32'h3C);
    aw(`IHW_PORT_LO);
    rd("pixel_port", 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("pslverr", {31'h0, se}, 32'h1);
    $display("test regs done");
  endtask
  task t_window;
    aw(`IHW_PANEL_W);
    dw(16'h0002);
    aw(`IHW_PANEL_HLO);
    dw(16'h0004);
    dw(16'h0000);
    aw(`IHW_DISP_SRC);
    dw(16'h00A0);
    chk("disp_src", {28'h0, disp_src}, 32'hA);
    aw(`IHW_WCTL);
    dw(16'h0010);
    aw(`IHW_BUF_SIZE);
    dw(16'h0001);
    aw(`IHW_XS);
    dw(16'h0001);
    dw(16'h0001);
    dw(16'h0001);
    dw(16'h0000);
    dw(16'h0002);
    dw(16'h0000);
    for (int i = 0; i < 16; i++) begin
      dw(16'h0100 + i[15:0]);
      px(24'h001000 + 24'((1 + i / 8) * 16 + 8 + i % 8), 16'h0100 + i[15:0]);
      if (i == 8) begin
        chk("walk_busy", {31'h0, walk_busy}, 32'h1);
      end
    end
    chk("mem_buf", {28'h0, mem_buf}, 32'h1);
    chk("walk_done", {31'h0, walk_busy}, 32'h0);
    dw(16'h0F0F);
    chk("idle_drop", qa.size(), 32'h0);
    $display("test window done");
  endtask
  task t_orient;
    logic [1:0]  m;
    logic [23:0] ea;
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      ea = 24'h001000 + (m[0] ? 24'h20 : 24'h10) + ((m[0] ^ m[1]) ? 24'h7 : 24'h8);
      aw(`IHW_WCTL);
      dw({12'h001, 2'b00, m});
      aw(`IHW_PORT_LO);
      dw(16'h0A00);
      px(ea, 16'h0A00);
    end
    $display("test orient done");
  endtask
  task t_trans;
    aw(`IHW_WCTL);
    dw(16'h0018);
    aw(`IHW_PORT_LO);
    dw(16'h3CA5);
    dw(16'h5555);
    px(24'h001019, 16'h5555);
    $display("test trans done");
  endtask
  task t_bus8;
    bus8_sel <= 1'b1;
    repeat (6) @(posedge pclk);
    aw(`IHW_WCTL);
    dw(16'h0020);
    aw(`IHW_PORT_LO);
    dw(16'h0034);
    chk("odd_byte", qa.size(), 32'h0);
    dw(16'h0012);
    px(24'h002018, 16'h1234);
    chk("mem_buf", {28'h0, mem_buf}, 32'h2);
    $display("test bus8 done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    err_total++;
    end_sim;
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    bus8_sel = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs;
    t_window;
    t_orient;
    t_trans;
    t_bus8;
    end_sim;
  end
endmodule
`default_nettype wire
